// file: rtl/pll_regs_consts.svh
// offsets, field positions, reset values for the pll control bank
`ifndef PLL_REGS_CONSTS_SVH
`define PLL_REGS_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_PLL_POWERDOWN 12'h791
`define IDX_PLL_CAL_DIV_RESET 12'h792
`define IDX_PLL_REF_PREDIV 12'h793
`define IDX_PLL_CP_CURRENT 12'h794
`define IDX_PLL_CP_CAL 12'h795
`define IDX_PLL_OPT_A 12'h796
`define IDX_PLL_OPT_B 12'h797
`define IDX_PLL_STATUS 12'h7B5

// field positions
`define POS_CAL_RESET 1
`define POS_DIV_HOLD 0
`define POS_PLL_LOCK 0

// reset values
`define RST_POWERDOWN 2'h0
`define RST_CAL_RESET 1'h1
`define RST_DIV_HOLD 1'h0
`define RST_PREDIV 2'h0
`define RST_CP_CURRENT 8'h04
`define RST_CP_CAL 8'h08
`define RST_OPT_A 8'hD2
`define RST_OPT_B 8'h20

// charge pump current step and base, microamps
`define CP_STEP_UA 13'h0064
`define CP_BASE_UA 13'h0064

`endif

// file: rtl/pll_regs_pkg.sv
// types shared by the pll control bank
package pll_regs_pkg;

  // control levels driven to the analog pll
  typedef struct packed {
    logic [1:0] pll_powerdown;
    logic vco_cal_reset;
    logic vco_divider_hold;
    logic adc_clk_drv_en;
    logic [1:0] ref_prediv_code;
    logic [2:0] ref_prediv_ratio;
    logic [5:0] charge_pump_current_code;
    logic [12:0] charge_pump_current_ua;
    logic [3:0] charge_pump_calibration_field;
    logic [3:0] pll_optimization_nibble;
    logic [5:0] pll_optimization_field;
  } pll_ctrl_t;

  // apb request as seen by the slave
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } apb_req_t;

  // apb answer
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

endpackage

// file: rtl/pll_ctrl_regs.sv
// apb register bank steering the converter's clock-multiplying pll
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "pll_regs_consts.svh"

module pll_ctrl_regs
(
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  // apb slave
  input wire pll_regs_pkg::apb_req_t I_APB,
  output pll_regs_pkg::apb_rsp_t O_APB,
  // analog pll side
  input wire logic I_PLL_LOCK,
  output pll_regs_pkg::pll_ctrl_t O_PLL_CTRL
);
  import pll_regs_pkg::*;

  // register state
  logic [1:0] powerdown_r, powerdown_nxt;
  logic cal_reset_r, cal_reset_nxt;
  logic div_hold_r, div_hold_nxt;
  logic [1:0] prediv_r, prediv_nxt;
  logic [7:0] cp_current_r, cp_current_nxt;
  logic [7:0] cp_cal_r, cp_cal_nxt;
  logic [7:0] opt_a_r, opt_a_nxt;
  logic [7:0] opt_b_r, opt_b_nxt;
  logic [2:0] ratio_r, ratio_nxt;
  logic [12:0] cp_ua_r, cp_ua_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic lock_s1_r, lock_s2_r, lock_s3_r;
  logic lock_r, lock_nxt;

  // decoded bus state
  logic hit;
  logic setup_phase;
  logic do_write;
  logic [11:0] idx;

  // address decode: aligned word, index is the word number
  function automatic logic addr_mapped(input logic [15:0] a);
    logic [11:0] w;
    w = a[13:2];
    addr_mapped = (a[1:0] == 2'h0) && (a[15:14] == 2'h0) &&
                  ((w >= `IDX_PLL_POWERDOWN && w <= `IDX_PLL_OPT_B) ||
                   w == `IDX_PLL_STATUS);
  endfunction

  // n minus one coding of the predivider
  function automatic logic [2:0] prediv_ratio(input logic [1:0] code);
    prediv_ratio = {1'b0, code} + 3'h1;
  endfunction

  // charge pump current in microamps
  function automatic logic [12:0] cp_current_ua(input logic [5:0] code);
    logic [18:0] prod;
    prod = 19'(code) * 19'(`CP_STEP_UA);
    cp_current_ua = 13'(prod) + `CP_BASE_UA;
  endfunction

  assign idx = I_APB.paddr[13:2];
  assign hit = addr_mapped(I_APB.paddr);
  assign setup_phase = I_APB.psel && !I_APB.penable;
  // writes land at the access edge, only the low byte lane carries data
  assign do_write = I_APB.psel && I_APB.penable && I_APB.pwrite &&
                    hit && I_APB.pstrb[0];

  // next values of the writable registers
  always_comb
  begin
    powerdown_nxt = powerdown_r;
    cal_reset_nxt = cal_reset_r;
    div_hold_nxt = div_hold_r;
    prediv_nxt = prediv_r;
    cp_current_nxt = cp_current_r;
    cp_cal_nxt = cp_cal_r;
    opt_a_nxt = opt_a_r;
    opt_b_nxt = opt_b_r;
    if (do_write)
    begin
      unique case (idx)
        `IDX_PLL_POWERDOWN: powerdown_nxt = I_APB.pwdata[1:0];
        `IDX_PLL_CAL_DIV_RESET:
        begin
          cal_reset_nxt = I_APB.pwdata[`POS_CAL_RESET];
          div_hold_nxt = I_APB.pwdata[`POS_DIV_HOLD];
        end
        `IDX_PLL_REF_PREDIV: prediv_nxt = I_APB.pwdata[1:0];
        `IDX_PLL_CP_CURRENT: cp_current_nxt = I_APB.pwdata[7:0];
        `IDX_PLL_CP_CAL: cp_cal_nxt = I_APB.pwdata[7:0];
        `IDX_PLL_OPT_A: opt_a_nxt = I_APB.pwdata[7:0];
        `IDX_PLL_OPT_B: opt_b_nxt = I_APB.pwdata[7:0];
        default: ; // status is read only
      endcase
    end
    // derived analog codes are flopped so outputs come from registers
    ratio_nxt = prediv_ratio(prediv_nxt);
    cp_ua_nxt = cp_current_ua(cp_current_nxt[5:0]);
  end

  // register file, synchronous reset
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RST_N)
    begin
      powerdown_r <= `RST_POWERDOWN;
      cal_reset_r <= `RST_CAL_RESET;
      div_hold_r <= `RST_DIV_HOLD;
      prediv_r <= `RST_PREDIV;
      cp_current_r <= `RST_CP_CURRENT;
      cp_cal_r <= `RST_CP_CAL;
      opt_a_r <= `RST_OPT_A;
      opt_b_r <= `RST_OPT_B;
      ratio_r <= 3'h1;
      cp_ua_r <= 13'h01F4;
    end
    else
    begin
      powerdown_r <= powerdown_nxt;
      cal_reset_r <= cal_reset_nxt;
      div_hold_r <= div_hold_nxt;
      prediv_r <= prediv_nxt;
      cp_current_r <= cp_current_nxt;
      cp_cal_r <= cp_cal_nxt;
      opt_a_r <= opt_a_nxt;
      opt_b_r <= opt_b_nxt;
      ratio_r <= ratio_nxt;
      cp_ua_r <= cp_ua_nxt;
    end
  end

  // lock arrives from the analog domain; accept it once stages 2 and 3 agree
  always_comb
  begin
    lock_nxt = lock_r;
    if (lock_s2_r == lock_s3_r)
    begin
      lock_nxt = lock_s3_r;
    end
  end

  // lock synchroniser, first stage feeds only the second
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RST_N)
    begin
      lock_s1_r <= 1'h0;
      lock_s2_r <= 1'h0;
      lock_s3_r <= 1'h0;
      lock_r <= 1'h0;
    end
    else
    begin
      lock_s1_r <= I_PLL_LOCK;
      lock_s2_r <= lock_s1_r;
      lock_s3_r <= lock_s2_r;
      lock_r <= lock_nxt;
    end
  end

  // read data is captured in the setup cycle so prdata is a flop
  always_comb
  begin
    prdata_nxt = prdata_r;
    if (setup_phase)
    begin
      prdata_nxt = 32'h0000_0000;
      if (hit && !I_APB.pwrite)
      begin
        unique case (idx)
          `IDX_PLL_POWERDOWN: prdata_nxt[1:0] = powerdown_r;
          `IDX_PLL_CAL_DIV_RESET:
          begin
            prdata_nxt[`POS_CAL_RESET] = cal_reset_r;
            prdata_nxt[`POS_DIV_HOLD] = div_hold_r;
          end
          `IDX_PLL_REF_PREDIV: prdata_nxt[1:0] = prediv_r;
          `IDX_PLL_CP_CURRENT: prdata_nxt[7:0] = cp_current_r;
          `IDX_PLL_CP_CAL: prdata_nxt[7:0] = cp_cal_r;
          `IDX_PLL_OPT_A: prdata_nxt[7:0] = opt_a_r;
          `IDX_PLL_OPT_B: prdata_nxt[7:0] = opt_b_r;
          `IDX_PLL_STATUS: prdata_nxt[`POS_PLL_LOCK] = lock_r;
          default: prdata_nxt = 32'h0000_0000;
        endcase
      end
    end
  end

  // read data register
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RST_N)
    begin
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      prdata_r <= prdata_nxt;
    end
  end

  // zero wait states; unmapped or misaligned addresses answer with slverr
  always_comb
  begin
    O_APB.pready = I_APB.psel && I_APB.penable;
    O_APB.pslverr = I_APB.psel && I_APB.penable && !hit;
    O_APB.prdata = prdata_r;
  end

  // analog controls straight from the register bits
  always_comb
  begin
    O_PLL_CTRL.pll_powerdown = powerdown_r;
    O_PLL_CTRL.vco_cal_reset = cal_reset_r;
    O_PLL_CTRL.vco_divider_hold = div_hold_r;
    // holding the divider also shuts the adc clock driver in and out
    O_PLL_CTRL.adc_clk_drv_en = !div_hold_r;
    O_PLL_CTRL.ref_prediv_code = prediv_r;
    O_PLL_CTRL.ref_prediv_ratio = ratio_r;
    O_PLL_CTRL.charge_pump_current_code = cp_current_r[5:0];
    O_PLL_CTRL.charge_pump_current_ua = cp_ua_r;
    O_PLL_CTRL.charge_pump_calibration_field = cp_cal_r[3:0];
    O_PLL_CTRL.pll_optimization_nibble = opt_a_r[7:4];
    O_PLL_CTRL.pll_optimization_field = opt_b_r[5:0];
  end

endmodule
`default_nettype wire

// file: sim/pll_ctrl_regs_checker.sv
// assertions on the ports of the pll control register bank
`timescale 1ns/1ps
`default_nettype none
`include "pll_regs_consts.svh"
module pll_ctrl_regs_checker
(
  // watched ports
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  input wire pll_regs_pkg::apb_req_t I_APB,
  input wire pll_regs_pkg::apb_rsp_t O_APB,
  input wire logic I_PLL_LOCK,
  input wire pll_regs_pkg::pll_ctrl_t O_PLL_CTRL
);
  import pll_regs_pkg::*;
  // decode of a taken write; byte lane 0 gates it
  wire logic acc = I_APB.psel && I_APB.penable;
  wire logic wr = acc && I_APB.pwrite && I_APB.pstrb[0];
  wire logic [11:0] ix = I_APB.paddr[13:2];
  wire logic ok = I_APB.paddr[15:14] == 2'h0 && I_APB.paddr[1:0] == 2'h0;
  wire pll_ctrl_t c = O_PLL_CTRL;
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);
  a_adc_drv_gate: assert property (
    c.adc_clk_drv_en == !c.vco_divider_hold) else $error("adc gate");
  a_divhold_write: assert property (
    wr && ok && ix == `IDX_PLL_CAL_DIV_RESET |=>
    c.vco_divider_hold == $past(I_APB.pwdata[0]) &&
    c.vco_cal_reset == $past(I_APB.pwdata[1])) else $error("ctrl0 write");
  a_prediv_ratio: assert property (
    c.ref_prediv_ratio == {1'h0, c.ref_prediv_code} + 3'h1)
    else $error("prediv ratio");
  a_cp_current: assert property (
    c.charge_pump_current_ua == 13'h0064 + 13'h0064 *
    c.charge_pump_current_code) else $error("pump current");
  a_cp_write: assert property (
    wr && ok && ix == `IDX_PLL_CP_CURRENT |=>
    c.charge_pump_current_code == $past(I_APB.pwdata[5:0]))
    else $error("pump code write");
  a_opt_reset: assert property (
    $rose(I_RST_N) |-> c.pll_optimization_nibble == 4'hD &&
    c.pll_optimization_field == 6'h20 &&
    c.charge_pump_calibration_field == 4'h8) else $error("opt reset");
  a_cal_held: assert property (
    $rose(I_RST_N) |-> c.vco_cal_reset && !c.vco_divider_hold)
    else $error("cal reset value");
  a_idle_stable: assert property (
    !wr |=> $stable(c)) else $error("control moved without write");
  a_status_read: assert property (
    acc && !I_APB.pwrite && ok && ix == `IDX_PLL_STATUS |->
    O_APB.prdata[31:1] == 31'h0) else $error("status upper bits");
endmodule
bind pll_ctrl_regs pll_ctrl_regs_checker pll_ctrl_regs_checker_i (
  .I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .I_APB(I_APB),
  .O_APB(O_APB), .I_PLL_LOCK(I_PLL_LOCK), .O_PLL_CTRL(O_PLL_CTRL));
`default_nettype wire

// file: sim/pll_ctrl_regs_tb.sv
// self-checking bench for the pll control register bank
`timescale 1ns/1ps
`default_nettype none
`include "pll_regs_consts.svh"
module pll_ctrl_regs_tb;
  import pll_regs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic lock = 1'b0;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  pll_ctrl_t ctl;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic err;
  logic [7:0] rst_tab [7] = '{8'h00, 8'h02, 8'h00, 8'h04, 8'h08, 8'hD2,
    8'h20};
  pll_ctrl_regs pll_ctrl_regs_i (.I_REF_CLK(clk), .I_RST_N(rst_n),
    .I_APB(req), .O_APB(rsp), .I_PLL_LOCK(lock), .O_PLL_CTRL(ctl));
  // 25 MHz reference
  always #20 clk = ~clk;
  // hang guard; the run needs under a hundred cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      n_errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer by word index; waits for pready, no fixed latency
  task automatic xfer(input logic w, input logic [13:0] ix,
    input logic [7:0] d);
    @(posedge clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= {ix, 2'h0};
    req.pwdata <= {24'h0, d};
    req.pstrb <= 4'hF;
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // reset contents of the seven writable registers
    for (int i = 0; i < 7; i++)
    begin
      xfer(1'b0, 14'(14'h791 + i), 8'h00);
      chk(rd, {24'h0, rst_tab[i]});
    end
    chk({ctl.adc_clk_drv_en, ctl.charge_pump_current_ua}, 14'h21F4);
    // every predivider code, read back and as ratio; software picks one
    // that keeps the pfd high and legal, the bank only stores it
    for (int k = 0; k < 4; k++)
    begin
      xfer(1'b1, `IDX_PLL_REF_PREDIV, 8'(k));
      xfer(1'b0, `IDX_PLL_REF_PREDIV, 8'h00);
      chk(rd, k);
      chk(ctl.ref_prediv_ratio, k + 1);
    end
    // top pump code
    xfer(1'b1, `IDX_PLL_CP_CURRENT, 8'hFF);
    // the write lands at the edge the task returns on; let it settle
    @(posedge clk);
    chk(ctl.charge_pump_current_ua, 13'h1900);
    // divider held, calibration released; reserved bits read zero
    xfer(1'b1, `IDX_PLL_CAL_DIV_RESET, 8'hFD);
    xfer(1'b0, `IDX_PLL_CAL_DIV_RESET, 8'h00);
    chk(rd, 32'h1);
    chk({ctl.vco_cal_reset, ctl.vco_divider_hold,
      ctl.adc_clk_drv_en}, 3'h2);
    // bypass: software sets both remaining powerdown bits
    xfer(1'b1, `IDX_PLL_POWERDOWN, 8'h03);
    @(posedge clk);
    chk(ctl.pll_powerdown, 2'h3);
    // lock through the synchroniser; status ignores writes
    lock <= 1'b1;
    repeat (6) @(posedge clk);
    xfer(1'b1, `IDX_PLL_STATUS, 8'h00);
    xfer(1'b0, `IDX_PLL_STATUS, 8'h00);
    chk(rd, 32'h1);
    // unmapped word is refused
    xfer(1'b0, 14'h0800, 8'h00);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
